// >>> pkg/mbtcp_pkg.sv
// shared constants and types for the modbus tcp server framer
package mbtcp_pkg;
   localparam int MAX_CONN = 8;
   localparam int MAX_PDU = 253;
   localparam logic [15:0] DEF_PORT = 16'h01f6;
   localparam logic [15:0] PROTO_MODBUS = 16'h0000;
   // length field counts unit byte plus pdu
   localparam logic [15:0] LEN_MIN = 16'h0002;
   localparam logic [15:0] LEN_MAX = 16'h00fe;
   // header byte positions, most significant byte first
   localparam logic [8:0] H_TID_HI = 9'h000;
   localparam logic [8:0] H_TID_LO = 9'h001;
   localparam logic [8:0] H_PID_HI = 9'h002;
   localparam logic [8:0] H_PID_LO = 9'h003;
   localparam logic [8:0] H_LEN_HI = 9'h004;
   localparam logic [8:0] H_LEN_LO = 9'h005;
   localparam logic [8:0] H_UNIT = 9'h006;
   localparam logic [8:0] H_BYTES = 9'h007;
   // request pdu byte positions and lengths checked by the syntax stage
   localparam logic [7:0] P_SUB = 8'h01;
   localparam logic [7:0] P_BC16 = 8'h05;
   localparam logic [7:0] P_BC23 = 8'h09;
   localparam logic [7:0] PLEN_FC3 = 8'h05;
   localparam logic [7:0] PLEN_FC8 = 8'h05;
   localparam logic [7:0] PLEN_FC16 = 8'h06;
   localparam logic [7:0] PLEN_FC23 = 8'h0a;
   localparam logic [7:0] PLEN_FC43 = 8'h04;
   // function codes
   localparam logic [7:0] FC_RD_REGS = 8'h03;
   localparam logic [7:0] FC_DIAG = 8'h08;
   localparam logic [7:0] FC_WR_REGS = 8'h10;
   localparam logic [7:0] FC_RW_REGS = 8'h17;
   localparam logic [7:0] FC_DEV_ID = 8'h2b;
   localparam logic [7:0] SUB_DEV_ID = 8'h0e;
   localparam logic [7:0] FC_FILE_XFER = 8'h5a;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   // exception codes
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
   localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
   localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
   localparam logic [7:0] EXC_SRV_FAIL = 8'h04;
   localparam logic [7:0] EXC_ACK = 8'h05;
   localparam logic [7:0] EXC_BUSY = 8'h06;
   localparam logic [7:0] EXC_GW_PATH = 8'h0a;
   localparam logic [7:0] EXC_GW_TARGET = 8'h0b;
   localparam logic [7:0] RLEN_EXC = 8'h02;
   localparam logic [7:0] RLEN_MAX_DATA = 8'hfc;
   localparam logic [3:0] AGE_MAX = 4'hf;
   typedef enum logic [2:0] {S_HDR, S_PDU, S_CHECK, S_WAIT, S_TX, S_DROP} state_e;
endpackage

// >>> src/fc_check.sv
// function code recognition and request syntax check
`timescale 1ns/1ps
module fc_check import mbtcp_pkg::*; (
   // request fields
   input wire logic [7:0] fc,
   input wire logic [7:0] sub,
   input wire logic [7:0] bc16,
   input wire logic [7:0] bc23,
   input wire logic [7:0] plen,
   // verdict
   output logic known,
   output logic malformed,
   output logic bad_value
);
   logic [8:0] need16;
   logic [8:0] need23;
   assign need16 = {1'b0, PLEN_FC16} + {1'b0, bc16};
   assign need23 = {1'b0, PLEN_FC23} + {1'b0, bc23};
   always_comb begin
      known = 1'b1;
      malformed = 1'b0;
      bad_value = 1'b0;
      case (fc)
         FC_RD_REGS: malformed = (plen != PLEN_FC3);
         FC_DIAG: malformed = (plen < PLEN_FC8);
         // byte count must match what actually arrived
         FC_WR_REGS: malformed = ({1'b0, plen} != need16);
         FC_RW_REGS: malformed = ({1'b0, plen} != need23);
         FC_DEV_ID: begin
            malformed = (plen != PLEN_FC43);
            bad_value = (sub != SUB_DEV_ID);
         end
         FC_FILE_XFER: malformed = 1'b0;
         default: known = 1'b0;
      endcase
   end
endmodule // fc_check

// >>> src/conn_table.sv
// connection slot table with least recently used eviction
`timescale 1ns/1ps
module conn_table import mbtcp_pkg::*; #(
   parameter int N_CONN = MAX_CONN
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // open requests from the stack
   input wire logic open_req,
   input wire logic [15:0] open_port,
   input wire logic [15:0] listen_port,
   output logic open_ack,
   output logic [2:0] open_id,
   output logic open_reject,
   output logic evict,
   // slot activity
   input wire logic use_en,
   input wire logic [2:0] use_id,
   input wire logic close_en,
   input wire logic [2:0] close_id,
   input wire logic drop_en,
   input wire logic [2:0] drop_id,
   input wire logic [N_CONN-1:0] busy_mask
);
   if (N_CONN < 1 || N_CONN > MAX_CONN) begin : g_bad_n
      $error("conn_table: N_CONN out of range");
   end
   typedef struct packed {
      logic [N_CONN-1:0] active;
      logic [N_CONN-1:0][3:0] age;
      logic ack;
      logic rej;
      logic evict;
      logic [2:0] id;
   } tab_s;
   tab_s cur;
   tab_s next_cur;
   logic free_ok;
   logic vict_ok;
   logic [2:0] free_id;
   logic [2:0] vict_id;
   logic [3:0] vict_age;
   always_comb begin
      next_cur = cur;
      next_cur.ack = 1'b0;
      next_cur.rej = 1'b0;
      next_cur.evict = 1'b0;
      free_ok = 1'b0;
      vict_ok = 1'b0;
      free_id = 3'h0;
      vict_id = 3'h0;
      vict_age = 4'h0;
      for (int i = N_CONN - 1; i >= 0; i--) begin
         if (!cur.active[i]) begin
            free_ok = 1'b1;
            free_id = 3'(i);
         end
      end
      // a slot marked in busy_mask cannot be evicted under it
      for (int i = 0; i < N_CONN; i++) begin
         if (cur.active[i] && !busy_mask[i] && (!vict_ok || cur.age[i] > vict_age)) begin
            vict_ok = 1'b1;
            vict_id = 3'(i);
            vict_age = cur.age[i];
         end
      end
      if (use_en) begin
         for (int i = 0; i < N_CONN; i++) begin
            if (use_id == 3'(i)) next_cur.age[i] = 4'h0;
            else if (cur.age[i] != AGE_MAX) next_cur.age[i] = cur.age[i] + 4'h1;
         end
      end
      if (close_en) next_cur.active[close_id] = 1'b0;
      if (drop_en) next_cur.active[drop_id] = 1'b0;
      if (open_req) begin
         if (open_port != listen_port) begin
            next_cur.rej = 1'b1;
         end else if (free_ok) begin
            next_cur.ack = 1'b1;
            next_cur.id = free_id;
            next_cur.active[free_id] = 1'b1;
            next_cur.age[free_id] = 4'h0;
         end else if (vict_ok) begin
            next_cur.ack = 1'b1;
            next_cur.evict = 1'b1;
            next_cur.id = vict_id;
            // reopen wins over a same-cycle close of the victim
            next_cur.active[vict_id] = 1'b1;
            next_cur.age[vict_id] = 4'h0;
         end else begin
            next_cur.rej = 1'b1;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cur <= '0;
      else cur <= next_cur;
   end
   assign open_ack = cur.ack;
   assign open_id = cur.id;
   assign open_reject = cur.rej;
   assign evict = cur.evict;

   chk_evict_full: assert property (@(posedge clk) disable iff (!rst_n)
      (open_req && open_port == listen_port && &cur.active && !close_en && !drop_en)
      |=> (evict && open_ack) || (open_reject && !open_ack))
      else $error("full table did not evict or reject");
endmodule // conn_table

// >>> src/mbtcp_server_framer.sv
// modbus tcp server frame parser, checker and response builder
`timescale 1ns/1ps
//
// Overview of operation
// - malformed pdu drops its connection, no answer
// - other errors answer with an exception; a bad protocol identifier or length in the header drops the connection instead
// - positive response echoes request function code
// - unknown function code gives exception 01
// - address error 02, value error 03
// - unfinished processing gives exception 04
// - long running request acknowledged with 05
// - busy gives 06; client decides resend
// - gateway path 0a, no target reply 0b
// - seven byte header precedes every frame
// - transaction identifier copied into response
// - protocol identifier zero, echoed back
// - length counts unit, function and data
// - unit identifier returned unchanged
// - frame boundaries found from header length
// - variable data carries a byte count
// - frame at most 260, pdu 253
// - multi byte fields most significant first
// - listen port 502, changeable by configuration
// - back to back requests accepted and answered
// - eight connections, evict least recently used
// - server closes only on listed causes
// - implement 3, 8, 16, 23, 43/14, 90
module mbtcp_server_framer import mbtcp_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration
   input wire logic cfg_port_en,
   input wire logic [15:0] cfg_port,
   // connection events
   input wire logic open_req,
   input wire logic [15:0] open_port,
   output logic open_ack,
   output logic [2:0] open_id,
   output logic open_reject,
   output logic evict,
   input wire logic client_close,
   input wire logic [2:0] client_close_id,
   output logic drop,
   output logic [2:0] drop_id,
   // receive byte stream
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [7:0] rx_data,
   input wire logic [2:0] rx_conn,
   // transmit byte stream
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic [2:0] tx_conn,
   output logic tx_last,
   // application side
   output logic app_req,
   output logic [7:0] app_fc,
   output logic [7:0] app_unit,
   output logic [7:0] app_pdu_len,
   input wire logic app_busy,
   input wire logic [7:0] buf_rd_idx,
   output logic [7:0] buf_rd_data,
   input wire logic buf_wr_en,
   input wire logic [7:0] buf_wr_idx,
   input wire logic [7:0] buf_wr_data,
   input wire logic app_done,
   input wire logic [7:0] app_exc,
   input wire logic [7:0] app_resp_len
);
   typedef struct packed {
      state_e st;
      logic [2:0] conn;
      logic [8:0] cnt;
      logic [15:0] tid;
      logic [15:0] pid;
      logic [15:0] len;
      logic [7:0] unit;
      logic [7:0] fc;
      logic [7:0] exc;
      logic [7:0] rlen;
      logic [MAX_PDU-1:0][7:0] pdu;
      logic app_req;
      logic drop;
      logic touch;
   } frm_s;
   frm_s cur;
   frm_s next_cur;
   logic [7:0] plen;
   logic known;
   logic malformed;
   logic bad_value;
   logic [7:0] fc_out;
   logic [15:0] len_out;
   logic [8:0] tx_idx;
   logic [MAX_CONN-1:0] busy_mask;
   logic [15:0] listen_port;

   ////////////////////////////////////////////////////////////////////////////
   assign plen = 8'(cur.len - 16'h0001);
   assign listen_port = cfg_port_en ? cfg_port : DEF_PORT;
   assign busy_mask = (cur.st == S_HDR) ? '0 : MAX_CONN'(1) << cur.conn;

   fc_check u_fc_check (
      .fc(cur.pdu[0]),
      .sub(cur.pdu[P_SUB]),
      .bc16(cur.pdu[P_BC16]),
      .bc23(cur.pdu[P_BC23]),
      .plen(plen),
      .known(known),
      .malformed(malformed),
      .bad_value(bad_value)
   );

   conn_table #(.N_CONN(MAX_CONN)) u_conn_table (
      .clk(clk),
      .rst_n(rst_n),
      .open_req(open_req),
      .open_port(open_port),
      .listen_port(listen_port),
      .open_ack(open_ack),
      .open_id(open_id),
      .open_reject(open_reject),
      .evict(evict),
      .use_en(cur.touch),
      .use_id(cur.conn),
      .close_en(client_close),
      .close_id(client_close_id),
      .drop_en(cur.drop),
      .drop_id(cur.conn),
      .busy_mask(busy_mask)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_cur = cur;
      next_cur.app_req = 1'b0;
      next_cur.drop = 1'b0;
      next_cur.touch = 1'b0;
      case (cur.st)
         S_HDR: begin
            if (rx_valid && rx_ready) begin
               next_cur.cnt = cur.cnt + 9'h001;
               case (cur.cnt)
                  H_TID_HI: begin
                     next_cur.conn = rx_conn;
                     next_cur.tid[15:8] = rx_data;
                  end
                  H_TID_LO: next_cur.tid[7:0] = rx_data;
                  H_PID_HI: next_cur.pid[15:8] = rx_data;
                  H_PID_LO: next_cur.pid[7:0] = rx_data;
                  H_LEN_HI: next_cur.len[15:8] = rx_data;
                  H_LEN_LO: next_cur.len[7:0] = rx_data;
                  default: begin
                     next_cur.unit = rx_data;
                     next_cur.cnt = 9'h000;
                     // a bad length leaves no way to find the frame end
                     if (cur.pid != PROTO_MODBUS || cur.len < LEN_MIN || cur.len > LEN_MAX) begin
                        next_cur.st = S_DROP;
                        next_cur.drop = 1'b1;
                     end else begin
                        next_cur.st = S_PDU;
                     end
                  end
               endcase
            end
         end
         S_PDU: begin
            if (rx_valid && rx_ready) begin
               next_cur.pdu[cur.cnt[7:0]] = rx_data;
               next_cur.cnt = cur.cnt + 9'h001;
               if (cur.cnt[7:0] == plen - 8'h01) begin
                  next_cur.cnt = 9'h000;
                  next_cur.st = S_CHECK;
                  next_cur.touch = 1'b1;
               end
            end
         end
         S_CHECK: begin
            next_cur.fc = cur.pdu[0];
            next_cur.st = S_TX;
            next_cur.rlen = RLEN_EXC;
            if (malformed) begin
               next_cur.st = S_DROP;
               next_cur.drop = 1'b1;
            end else if (!known) begin
               next_cur.exc = EXC_ILL_FUNC;
            end else if (bad_value) begin
               next_cur.exc = EXC_ILL_VALUE;
            end else if (app_busy) begin
               next_cur.exc = EXC_BUSY;
            end else begin
               next_cur.exc = EXC_NONE;
               next_cur.app_req = 1'b1;
               next_cur.st = S_WAIT;
            end
            if (next_cur.st == S_TX) next_cur.pdu[1] = next_cur.exc;
         end
         S_WAIT: begin
            if (buf_wr_en && buf_wr_idx < 8'(MAX_PDU)) next_cur.pdu[buf_wr_idx] = buf_wr_data;
            if (app_done) begin
               next_cur.st = S_TX;
               next_cur.rlen = RLEN_EXC;
               // address, value, ack, busy and gateway codes come from the application
               if (app_exc != EXC_NONE) begin
                  next_cur.exc = app_exc;
                  next_cur.pdu[1] = app_exc;
               end else if (app_resp_len > RLEN_MAX_DATA) begin
                  next_cur.exc = EXC_SRV_FAIL;
                  next_cur.pdu[1] = EXC_SRV_FAIL;
               end else begin
                  next_cur.rlen = app_resp_len + 8'h01;
               end
            end
         end
         S_TX: begin
            if (tx_ready) begin
               next_cur.cnt = cur.cnt + 9'h001;
               if (tx_last) begin
                  next_cur.cnt = 9'h000;
                  next_cur.st = S_HDR;
               end
            end
         end
         S_DROP: begin
            next_cur.cnt = 9'h000;
            next_cur.st = S_HDR;
         end
         default: next_cur.st = S_HDR;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cur <= '0;
      else cur <= next_cur;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one frame at a time; other connections wait until its response is sent or the frame is dropped
   assign rx_ready = (cur.st == S_HDR && (cur.cnt == H_TID_HI || rx_conn == cur.conn))
                  || (cur.st == S_PDU && rx_conn == cur.conn);
   assign fc_out = (cur.exc != EXC_NONE) ? (cur.fc | EXC_FLAG) : cur.fc;
   assign len_out = {8'h00, cur.rlen + 8'h01};
   assign tx_idx = cur.cnt - H_BYTES;
   always_comb begin
      case (cur.cnt)
         H_TID_HI: tx_data = cur.tid[15:8];
         H_TID_LO: tx_data = cur.tid[7:0];
         H_PID_HI: tx_data = cur.pid[15:8];
         H_PID_LO: tx_data = cur.pid[7:0];
         H_LEN_HI: tx_data = len_out[15:8];
         H_LEN_LO: tx_data = len_out[7:0];
         H_UNIT: tx_data = cur.unit;
         H_BYTES: tx_data = fc_out;
         default: tx_data = cur.pdu[tx_idx[7:0]];
      endcase
   end
   assign tx_valid = (cur.st == S_TX);
   assign tx_conn = cur.conn;
   assign tx_last = tx_valid && (cur.cnt == 9'(cur.rlen) + H_UNIT);
   assign drop = cur.drop;
   assign drop_id = cur.conn;
   assign app_req = cur.app_req;
   assign app_fc = cur.fc;
   assign app_unit = cur.unit;
   assign app_pdu_len = plen;
   assign buf_rd_data = (buf_rd_idx < 8'(MAX_PDU)) ? cur.pdu[buf_rd_idx] : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_drop_malformed: assert property ((cur.st == S_CHECK && malformed)
      |=> drop && !tx_valid ##1 cur.st == S_HDR && !drop)
      else $error("malformed pdu did not drop connection");
   chk_exc_length: assert property ((tx_valid && cur.exc != EXC_NONE && cur.cnt == H_LEN_LO)
      |-> tx_data == 8'h03)
      else $error("exception length not three");
   chk_exc_fc: assert property ((tx_valid && cur.exc != EXC_NONE && cur.cnt == H_BYTES)
      |-> tx_data == (cur.fc | 8'h80))
      else $error("exception function code wrong");
   chk_pos_fc: assert property ((tx_valid && cur.exc == EXC_NONE && cur.cnt == H_BYTES)
      |-> tx_data == cur.fc)
      else $error("positive function code not echoed");
   chk_tid_echo: assert property ((rx_valid && rx_ready && cur.st == S_HDR && cur.cnt == H_TID_HI)
      |=> cur.tid[15:8] == $past(rx_data))
      else $error("transaction id not captured");
   chk_unit_echo: assert property ((tx_valid && cur.cnt == H_UNIT) |-> tx_data == cur.unit)
      else $error("unit id not echoed");
   chk_unknown_fc: assert property ((cur.st == S_CHECK && !malformed && !known)
      |=> cur.st == S_TX && cur.exc == 8'h01 && cur.rlen == 8'h02)
      else $error("unknown function code not refused with 01");
   chk_busy_exc: assert property ((cur.st == S_CHECK && !malformed && known && !bad_value && app_busy)
      |=> cur.exc == 8'h06 && !app_req)
      else $error("busy not answered with 06");
   chk_tx_last: assert property ((tx_valid && tx_ready && tx_last) |=> !tx_valid)
      else $error("transmit did not return to receive");
endmodule // mbtcp_server_framer

// >>> testbench/mb_client.sv
// remote client model: feeds request bytes, collects response bytes
`timescale 1ns/1ps
module mb_client (
   // clock
   input wire logic clk,
   // request stream
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   output logic [2:0] rx_conn,
   // response stream
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic [2:0] tx_conn,
   input wire logic tx_last
);
   logic [7:0] q[$];
   logic [7:0] rsp[$];
   logic took = 0;
   int last_n = 0;
   logic [2:0] got_conn = 3'h0;
   initial begin
      rx_valid = 0;
      rx_data = 8'h00;
      rx_conn = 3'h0;
      tx_ready = 1;
   end
   ////////////////////////////////
   always @(posedge clk) begin
      took = rx_valid && rx_ready;
      if (took) void'(q.pop_front());
      if (tx_valid && tx_ready) begin
         rsp.push_back(tx_data);
         got_conn = tx_conn;
         if (tx_last) last_n = rsp.size();
      end
   end
   // gaps split frames like segments; a byte holds until taken
   always @(negedge clk) begin
      if (!rx_valid || took) begin
         if (q.size() != 0 && $urandom % 4 != 0) begin
            rx_valid = 1;
            rx_data = q[0];
         end else begin
            rx_valid = 0;
            rx_data = ~rx_data; // released line shows no stale byte
         end
      end
      tx_ready = $urandom % 3 != 0;
   end
   // never resends on its own; the bench decides
endmodule // mb_client

// >>> testbench/tb.sv
// self-checking bench for the modbus tcp server framer
`timescale 1ns/1ps
module tb;
   import mbtcp_pkg::*;
   logic clk = 0;
   logic rst_n = 0;
   logic cfg_port_en = 0;
   logic [15:0] cfg_port = 16'h0000;
   logic open_req = 0;
   logic [15:0] open_port = 16'h0000;
   logic open_ack, open_reject, evict, drop, rx_valid, rx_ready, tx_valid, tx_ready, tx_last, app_req;
   logic [2:0] open_id, drop_id, rx_conn, tx_conn;
   logic [7:0] rx_data, tx_data, app_fc, app_unit, app_pdu_len, buf_rd_data;
   logic client_close = 0;
   logic [2:0] client_close_id = 3'h0;
   logic app_busy = 0, buf_wr_en = 0, app_done = 0;
   logic [7:0] buf_rd_idx = 8'h01, buf_wr_idx = 8'h00, buf_wr_data = 8'h00, app_exc = 8'h00, app_resp_len = 8'h00;
   logic [7:0] p[$];
   logic [7:0] codes[7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0a, 8'h0b};
   logic [7:0] fcs[6] = '{FC_RD_REGS, FC_DIAG, FC_WR_REGS, FC_RW_REGS, FC_DEV_ID, FC_FILE_XFER};
   int miscompares = 0;
   int checked = 0;
   always #50 clk = ~clk;
   mbtcp_server_framer i_mbtcp_server_framer (.clk(clk), .rst_n(rst_n), .cfg_port_en(cfg_port_en),
      .cfg_port(cfg_port), .open_req(open_req), .open_port(open_port), .open_ack(open_ack), .open_id(open_id),
      .open_reject(open_reject), .evict(evict), .client_close(client_close), .client_close_id(client_close_id),
      .drop(drop), .drop_id(drop_id), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .rx_conn(rx_conn), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_conn(tx_conn),
      .tx_last(tx_last), .app_req(app_req), .app_fc(app_fc), .app_unit(app_unit), .app_pdu_len(app_pdu_len),
      .app_busy(app_busy), .buf_rd_idx(buf_rd_idx), .buf_rd_data(buf_rd_data), .buf_wr_en(buf_wr_en),
      .buf_wr_idx(buf_wr_idx), .buf_wr_data(buf_wr_data), .app_done(app_done), .app_exc(app_exc),
      .app_resp_len(app_resp_len));
   mb_client i_mb_client (.clk(clk), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .rx_conn(rx_conn), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_conn(tx_conn),
      .tx_last(tx_last));
   ////////////////////////////////
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // header then pdu, length counts unit byte onward
   function automatic void frame(ref logic [7:0] f[$], input logic [15:0] tid, pid, input logic [7:0] unit,
                                 input logic [7:0] pdu[$]);
      logic [15:0] len;
      len = 16'(pdu.size() + 1);
      f = {f, tid[15:8], tid[7:0], pid[15:8], pid[7:0], len[15:8], len[7:0], unit, pdu};
   endfunction
   // well-formed request, byte count where data varies
   function automatic void req(ref logic [7:0] r[$], input logic [7:0] fc);
      r = {fc, 8'($urandom), 8'($urandom), 8'h00, 8'h02};
      case (fc)
         FC_WR_REGS: r = {r, 8'h02, 8'($urandom), 8'($urandom)};
         FC_RW_REGS: r = {r, 8'($urandom), 8'($urandom), 8'h00, 8'h01, 8'h02, 8'($urandom), 8'($urandom)};
         FC_DEV_ID: r = {fc, SUB_DEV_ID, 8'h01, 8'h00};
         default: ;
      endcase
   endfunction
   task automatic open_conn(input logic [15:0] port, input logic a, r, e);
      @(negedge clk);
      open_port = port;
      open_req = 1;
      @(negedge clk);
      open_req = 0;
      chk("open_ack", open_ack, a);
      chk("open_reject", open_reject, r);
      chk("evict", evict, e);
   endtask
   task automatic run(input logic [7:0] pdu[$], input logic busy, use_app, input logic [7:0] exc, n, code,
                      input int reps);
      logic [7:0] f[$], e[$], d[$], rp[$];
      logic [15:0] tid;
      logic [7:0] unit;
      tid = 16'($urandom);
      unit = 8'($urandom);
      f = {};
      for (int i = 0; i < reps; i++) frame(f, tid + 16'(i), PROTO_MODBUS, unit, pdu);
      app_busy = busy;
      i_mb_client.q = f; // back to back when reps is two
      for (int i = 0; i < reps; i++) begin
         d = {};
         if (use_app) begin
            for (int k = 0; k < 400 && app_req !== 1'b1; k++) @(negedge clk);
            chk("app_req", app_req, 1'b1);
            chk("app_fc", app_fc, pdu[0]);
            chk("app_unit", app_unit, unit);
            chk("app_pdu_len", app_pdu_len, 8'(pdu.size()));
            chk("buf_rd_data", buf_rd_data, pdu[1]);
            for (int k = 1; k <= int'(n) && k < 9; k++) begin
               d.push_back(8'($urandom));
               @(negedge clk);
               buf_wr_en = 1;
               buf_wr_idx = 8'(k);
               buf_wr_data = d[k-1];
            end
            @(negedge clk);
            buf_wr_en = 0;
            app_exc = exc;
            app_resp_len = n;
            app_done = 1;
            @(negedge clk);
            app_done = 0;
         end
         if (code == EXC_NONE) rp = {pdu[0], d};
         else rp = {pdu[0] | EXC_FLAG, code};
         e = {};
         frame(e, tid + 16'(i), PROTO_MODBUS, unit, rp);
         for (int k = 0; k < 600 && i_mb_client.rsp.size() < e.size(); k++) @(negedge clk);
         chk("rsp_size", 16'(i_mb_client.rsp.size()), 16'(e.size()));
         foreach (e[k]) chk("rsp_byte", i_mb_client.rsp[k], e[k]);
         chk("tx_last", 16'(i_mb_client.last_n), 16'(e.size()));
         chk("tx_conn", i_mb_client.got_conn, i_mb_client.rx_conn);
         i_mb_client.rsp = {};
      end
      app_busy = 0;
   endtask
   task automatic bad(input logic [2:0] c, input logic [15:0] pid, input logic [7:0] pdu[$], input int keep);
      logic [7:0] f[$];
      f = {};
      frame(f, 16'($urandom), pid, 8'h01, pdu);
      i_mb_client.rx_conn = c;
      i_mb_client.q = f[0:keep-1];
      for (int k = 0; k < 300 && drop !== 1'b1; k++) @(negedge clk);
      chk("drop", drop, 1'b1);
      chk("drop_id", drop_id, c);
      repeat (40) @(negedge clk);
      chk("no_rsp", 16'(i_mb_client.rsp.size()), 16'h0000);
   endtask
   ////////////////////////////////
   initial begin
      #2000000;
      miscompares++;
      end_sim();
   end
   initial begin
      void'($urandom(2792));
      repeat (12) @(negedge clk);
      rst_n = 1;
      chk("rx_ready", rx_ready, 1'b1);
      open_conn(16'h0001, 0, 1, 0);
      cfg_port_en = 1;
      cfg_port = 16'($urandom) | 16'h0800;
      open_conn(cfg_port, 1, 0, 0);
      open_conn(DEF_PORT, 0, 1, 0);
      cfg_port_en = 0;
      for (int i = 0; i < 6; i++) open_conn(DEF_PORT, 1, 0, 0);
      open_conn(DEF_PORT, 1, 0, 0);
      open_conn(DEF_PORT, 1, 0, 1);
      chk("evict_id", open_id, 3'h0);
      @(negedge clk);
      client_close_id = 3'h5;
      client_close = 1;
      @(negedge clk);
      client_close = 0;
      open_conn(DEF_PORT, 1, 0, 0);
      chk("reuse_id", open_id, 3'h5);
      i_mb_client.rx_conn = 3'h2;
      for (int j = 0; j < 12; j++) begin
         req(p, fcs[j % 6]);
         run(p, 0, 1, EXC_NONE, 8'($urandom % 9), EXC_NONE, 1 + j / 6);
      end
      req(p, FC_RD_REGS);
      foreach (codes[j]) run(p, 0, 1, codes[j], 8'h00, codes[j], 1);
      run(p, 0, 1, EXC_NONE, 8'hfd, EXC_SRV_FAIL, 1);
      run(p, 1, 0, EXC_NONE, 8'h00, EXC_BUSY, 1);
      p[0] = 8'h07;
      run(p, 0, 0, EXC_NONE, 8'h00, EXC_ILL_FUNC, 1);
      p = {FC_DEV_ID, 8'h0d, 8'h01, 8'h00};
      run(p, 0, 0, EXC_NONE, 8'h00, EXC_ILL_VALUE, 1);
      bad(3'h2, 16'h0001, p, 7);
      p = {FC_RD_REGS, 8'h00, 8'h00, 8'h00};
      bad(3'h3, PROTO_MODBUS, p, 11);
      p = {};
      repeat (254) p.push_back(8'h03);
      bad(3'h4, PROTO_MODBUS, p, 7);
      end_sim();
   end
endmodule // tb
